// *** psl_mgmt_model.sv ***
// Station management model: control writes and addressed frames
`default_nettype none

module psl_mgmt_model (
    // Clock
    input  wire logic                       clock,
    // Management outputs
    output logic                            ctrl_hi_wr,
    output logic [psl_pkg::ADDR_W-1:0]      frame_addr,
    output logic                            frame_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    import psl_pkg::*;

    initial begin
        ctrl_hi_wr = 1'b0;
        frame_addr = '0;
        frame_valid = 1'b0;
    end

    // Upper byte write, one cycle
    task automatic soft_reset();
        ctrl_hi_wr <= 1'b1;
        @(posedge clock);
        ctrl_hi_wr <= 1'b0;
    endtask

    // Released field shows inverse
    task automatic send_frame(input logic [ADDR_W-1:0] a);
        frame_addr <= a;
        frame_valid <= 1'b1;
        @(posedge clock);
        frame_valid <= 1'b0;
        frame_addr <= ~a;
    endtask
endmodule // psl_mgmt_model

`default_nettype wire

// *** psl_pkg.sv ***
// Constants and types for the strap latch and reset sequencer
// ============================================================
// Operation
// - Sample five address straps at reset; keep the chosen one of 32 addresses.
// - Management write of control upper byte starts reset held for 500 ns; ignored in PSL_HOLD and PSL_DRIVE_WAIT.
// - Latch all mode and address straps when reset synchronously de-asserts.
// - Address strap drivers off from reset start until 1700 ns after assertion.
// - Strap level counts only once stable within 250 ns of reset assertion.
// - Low power input at 100 Mb/s powers down 10 Mb/s and negotiation circuits.
`default_nettype none

package psl_pkg;
    localparam int ADDR_W = 5;
    localparam int MODE_W = 4;
    localparam int SPD_BIT = 3;
    localparam int CLK_PS = 4000;
    localparam int RST_HOLD_NS = 500;
    localparam int OE_OFF_NS = 1700;
    localparam int SETTLE_NS = 250;
    // Least times round up
    localparam int RST_HOLD_CYC = (RST_HOLD_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int OE_OFF_CYC = (OE_OFF_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int SETTLE_CYC = (SETTLE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int CNT_W = 10;

    typedef enum logic [1:0] {
        PSL_RUN,
        PSL_HOLD,
        PSL_DRIVE_WAIT
    } psl_state_t;
endpackage : psl_pkg

`default_nettype wire

// *** psl_strap_reset.sv ***
// Strap latch and timed reset sequencer of the physical layer device
`default_nettype none

module psl_strap_reset (
    // Clock and reset
    input  wire logic                          clock,
    input  wire logic                          rst,
    // Management side
    input  wire logic                          ctrl_hi_wr,
    input  wire logic [psl_pkg::ADDR_W-1:0]    frame_addr,
    input  wire logic                          frame_valid,
    // Strap pins
    input  wire logic [psl_pkg::ADDR_W-1:0]    addr_strap_pins_in,
    output logic      [psl_pkg::ADDR_W-1:0]    addr_strap_pins_out,
    output logic      [psl_pkg::ADDR_W-1:0]    addr_strap_pins_oe,
    input  wire logic [psl_pkg::MODE_W-1:0]    mode_pins,
    // Status and power
    input  wire logic                          low_power,
    input  wire logic                          speed_100_int,
    output logic                               core_rst,
    output logic      [psl_pkg::ADDR_W-1:0]    phy_addr,
    output logic      [psl_pkg::MODE_W-1:0]    mode_cfg,
    output logic                               addr_match,
    output logic                               pwr_down_10_an
);
    import psl_pkg::*;

    localparam int PW = ADDR_W + MODE_W;

    typedef struct packed {
        psl_state_t         st;
        logic [CNT_W-1:0]   hold_cnt;
        logic [CNT_W-1:0]   oe_cnt;
        logic [PW-1:0]      s1;
        logic [PW-1:0]      s2;
        logic [PW-1:0]      s3;
        logic [PW-1:0]      pin_val;
        logic [ADDR_W-1:0]  addr;
        logic [MODE_W-1:0]  mode;
        logic               rst_o;
        logic               oe_on;
        logic               spd;
        logic               match;
        logic               pd;
        // Check-only counters, read by the assertions
        logic [CNT_W-1:0]   chk_hold;
        logic [CNT_W-1:0]   chk_oe;
    } psl_reg_t;

    psl_reg_t r;
    psl_reg_t next_r;

    // ============================================================
    // Next state
    always_comb begin
        next_r = r;
        next_r.s1 = {mode_pins, addr_strap_pins_in};
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        // Accept a strap change once two stages agree
        if (r.s2 == r.s3) begin
            next_r.pin_val = r.s3;
        end
        next_r.spd = speed_100_int;
        next_r.pd = low_power && speed_100_int;
        next_r.match = frame_valid && (frame_addr == r.addr);
        // Reset hold length and driver-off span, for the checks
        if (r.rst_o) begin
            next_r.chk_hold = r.chk_hold + 1'b1;
        end else begin
            next_r.chk_hold = '0;
        end
        if (r.oe_on) begin
            next_r.chk_oe = '0;
        end else if (r.chk_oe != '1) begin
            next_r.chk_oe = r.chk_oe + 1'b1;
        end
        if (r.oe_cnt != '0) begin
            next_r.oe_cnt = r.oe_cnt - 1'b1;
        end
        next_r.oe_on = (r.st == PSL_RUN) && (r.oe_cnt == '0);
        unique case (r.st)
            PSL_RUN: begin
                if (ctrl_hi_wr) begin
                    next_r.st = PSL_HOLD;
                    next_r.rst_o = 1'b1;
                    next_r.oe_on = 1'b0;
                    next_r.hold_cnt = CNT_W'(RST_HOLD_CYC - 1);
                    next_r.oe_cnt = CNT_W'(OE_OFF_CYC - 1);
                end
            end
            PSL_HOLD: begin
                if (r.hold_cnt == '0) begin
                    // Synchronous release; straps taken now
                    next_r.rst_o = 1'b0;
                    next_r.addr = r.pin_val[ADDR_W-1:0];
                    next_r.mode = r.pin_val[PW-1:ADDR_W];
                    next_r.st = PSL_DRIVE_WAIT;
                end else begin
                    next_r.hold_cnt = r.hold_cnt - 1'b1;
                end
            end
            PSL_DRIVE_WAIT: begin
                if (r.oe_cnt == '0) begin
                    next_r.st = PSL_RUN;
                end
            end
            default: begin
                // Unused code: restart the reset sequence
                next_r.st = PSL_HOLD;
                next_r.rst_o = 1'b1;
                next_r.hold_cnt = CNT_W'(RST_HOLD_CYC - 1);
                next_r.oe_cnt = CNT_W'(OE_OFF_CYC - 1);
            end
        endcase
    end

    // ============================================================
    // State register
    always_ff @(posedge clock) begin
        if (rst) begin
            r <= '0;
            r.st <= PSL_HOLD;
            r.rst_o <= 1'b1;
            r.hold_cnt <= CNT_W'(RST_HOLD_CYC - 1);
            r.oe_cnt <= CNT_W'(OE_OFF_CYC - 1);
        end else begin
            r <= next_r;
        end
    end

    // ============================================================
    // Outputs
    assign core_rst = r.rst_o;
    assign phy_addr = r.addr;
    assign mode_cfg = r.mode;
    assign addr_match = r.match;
    assign pwr_down_10_an = r.pd;

    // Only bit 3 is ever driven, as the speed indication
    generate
        for (genvar i = 0; i < ADDR_W; i++) begin : g_pin
            if (i == SPD_BIT) begin : g_spd
                assign addr_strap_pins_out[i] = r.spd;
                assign addr_strap_pins_oe[i] = r.oe_on;
            end else begin : g_in
                assign addr_strap_pins_out[i] = 1'b0;
                assign addr_strap_pins_oe[i] = 1'b0;
            end
        end
    endgenerate

    // ============================================================
    // Checks: reset sequencing
    AST_HOLD_LEN: assert property (@(posedge clock) disable iff (rst)
        $fell(r.rst_o) |-> r.chk_hold == CNT_W'(RST_HOLD_CYC))
        else $error("reset hold length wrong");
    AST_HOLD_SPAN: assert property (@(posedge clock) disable iff (rst)
        r.chk_hold <= CNT_W'(RST_HOLD_CYC))
        else $error("reset held too long");
    AST_SETTLE: assert property (@(posedge clock) disable iff (rst)
        $fell(r.rst_o) |-> r.chk_hold >= CNT_W'(SETTLE_CYC))
        else $error("hold shorter than settle window");
    AST_RST_START: assert property (@(posedge clock) disable iff (rst)
        ctrl_hi_wr && r.st == PSL_RUN |=> core_rst)
        else $error("software reset not started");
    AST_REFUSE: assert property (@(posedge clock) disable iff (rst)
        r.st == PSL_DRIVE_WAIT |=> !core_rst)
        else $error("reset restarted before drivers back");
    AST_RST_STATE: assert property (@(posedge clock) disable iff (rst)
        (r.st == PSL_HOLD) == r.rst_o)
        else $error("reset output and state disagree");
    AST_RST_DROP: assert property (@(posedge clock) disable iff (rst)
        $fell(r.rst_o) |-> r.st == PSL_DRIVE_WAIT)
        else $error("reset released in wrong state");

    // ============================================================
    // Checks: strap pins
    AST_OE_OFF: assert property (@(posedge clock) disable iff (rst)
        r.rst_o |-> !addr_strap_pins_oe[SPD_BIT])
        else $error("strap driver on during reset");
    AST_OE_LATE: assert property (@(posedge clock) disable iff (rst)
        $rose(r.oe_on) |-> r.chk_oe >= CNT_W'(OE_OFF_CYC))
        else $error("strap driver enable timing");
    AST_OE_BACK: assert property (@(posedge clock) disable iff (rst)
        $fell(r.rst_o) |-> ##[1:320] addr_strap_pins_oe[SPD_BIT])
        else $error("strap driver never re-enabled");
    AST_OE_RUN: assert property (@(posedge clock) disable iff (rst)
        r.oe_on |-> r.st == PSL_RUN)
        else $error("strap driver on outside run");
    AST_OE_BIT: assert property (@(posedge clock) disable iff (rst)
        (addr_strap_pins_oe & ~(ADDR_W'(1) << SPD_BIT)) == '0)
        else $error("non-speed strap pin driven");
    AST_SPD: assert property (@(posedge clock) disable iff (rst)
        r.oe_on |-> addr_strap_pins_out[SPD_BIT] == $past(speed_100_int))
        else $error("speed pin not driven from speed");
    AST_LATCH: assert property (@(posedge clock) disable iff (rst)
        $fell(r.rst_o) |-> r.addr == $past(r.pin_val[ADDR_W-1:0]))
        else $error("address not latched at release");
    AST_MODE_LATCH: assert property (@(posedge clock) disable iff (rst)
        $fell(r.rst_o) |-> r.mode == $past(r.pin_val[PW-1:ADDR_W]))
        else $error("mode not latched at release");
    AST_SYNC_AGREE: assert property (@(posedge clock) disable iff (rst)
        !$stable(r.pin_val) |-> $past(r.s2) == $past(r.s3) && r.pin_val == $past(r.s3))
        else $error("strap taken before stages agree");
    AST_SYNC_HOLD: assert property (@(posedge clock) disable iff (rst)
        r.s2 != r.s3 |=> $stable(r.pin_val))
        else $error("strap value moved while unsettled");
    AST_ADDR_STABLE: assert property (@(posedge clock) disable iff (rst)
        !r.rst_o && !$fell(r.rst_o) |-> $stable(r.addr))
        else $error("address changed outside reset");

    // ============================================================
    // Checks: management and power
    AST_MATCH: assert property (@(posedge clock) disable iff (rst)
        frame_valid && frame_addr != r.addr && $stable(r.addr) |=> !addr_match)
        else $error("match on wrong address");
    AST_MATCH_HIT: assert property (@(posedge clock) disable iff (rst)
        frame_valid && frame_addr == phy_addr |=> addr_match)
        else $error("no match on own address");
    AST_PWR: assert property (@(posedge clock) disable iff (rst)
        low_power && speed_100_int |=> pwr_down_10_an)
        else $error("low power not applied");
    AST_PWR_OFF: assert property (@(posedge clock) disable iff (rst)
        !(low_power && speed_100_int) |=> !pwr_down_10_an)
        else $error("power down without request at 100 Mb/s");
endmodule : psl_strap_reset

`default_nettype wire

// *** testbench.sv ***
// Testbench for the strap latch and reset sequencer
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import psl_pkg::*;
    // ============================================================
    // Signals
    logic              clock = 1'b0;
    logic              rst = 1'b1;
    logic              low_power = 1'b0;
    logic              speed_100_int = 1'b0;
    logic [ADDR_W-1:0] strap = 5'h0A;
    logic [MODE_W-1:0] mode_pins = 4'h5;
    logic              ctrl_hi_wr, frame_valid, core_rst, addr_match, pwr_down_10_an;
    logic [ADDR_W-1:0] frame_addr, pins_in, pins_out, pins_oe, phy_addr;
    logic [MODE_W-1:0] mode_cfg;
    int                bad_count = 0;
    int                compares = 0;

    always #2 clock = ~clock;
    // Pin level: driver wins where enabled, else strap resistor
    assign pins_in = (strap & ~pins_oe) | (pins_out & pins_oe);

    psl_mgmt_model mgmt_u (.clock(clock), .ctrl_hi_wr(ctrl_hi_wr),
        .frame_addr(frame_addr), .frame_valid(frame_valid));
    psl_strap_reset dut_u (.clock(clock), .rst(rst), .ctrl_hi_wr(ctrl_hi_wr),
        .frame_addr(frame_addr), .frame_valid(frame_valid), .addr_strap_pins_in(pins_in),
        .addr_strap_pins_out(pins_out), .addr_strap_pins_oe(pins_oe), .mode_pins(mode_pins),
        .low_power(low_power), .speed_100_int(speed_100_int), .core_rst(core_rst),
        .phy_addr(phy_addr), .mode_cfg(mode_cfg), .addr_match(addr_match),
        .pwr_down_10_an(pwr_down_10_an));

    // ============================================================
    // Helpers
    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic hold_len(inout int n);
        while (core_rst === 1'b1 && n < 1000) begin
            n++;
            @(posedge clock);
            #1;
        end
    endtask

    task automatic wait_oe(inout int n);
        while (pins_oe[3] !== 1'b1 && n < 1000) begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ============================================================
    // Scenarios
    task automatic power_on();
        int n = 0;
        hold_len(n);
        check("phy_addr", 8'(phy_addr), 8'h0A);
        check("mode_cfg", 8'(mode_cfg), 8'h05);
        check("oe", 8'(pins_oe), 8'h00);
        wait_oe(n);
        check("pins_oe", 8'(pins_oe), 8'h08);
        check("pins_out", 8'(pins_out), 8'h00);
        $display("test power_on done");
    endtask

    task automatic soft_seq();
        int n = 0;
        @(posedge clock);
        speed_100_int <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        check("speed_out", 8'(pins_out), 8'h08);
        @(posedge clock);
        mgmt_u.soft_reset();
        strap <= 5'h15;
        mode_pins <= 4'hA;
        #1;
        check("oe_in_reset", 8'(pins_oe), 8'h00);
        hold_len(n);
        check("hold", 8'(n), 8'(RST_HOLD_CYC));
        check("phy_addr", 8'(phy_addr), 8'h15);
        check("mode_cfg", 8'(mode_cfg), 8'h0A);
        wait_oe(n);
        check("oe_off_long", 8'(n >= OE_OFF_CYC), 8'h01);
        check("oe_back", 8'(pins_oe), 8'h08);
        check("speed_back", 8'(pins_out), 8'h08);
        $display("test soft_reset done");
    endtask

    task automatic frame_seq();
        @(posedge clock);
        mgmt_u.send_frame(5'h15);
        #1;
        check("match", 8'(addr_match), 8'h01);
        @(posedge clock);
        mgmt_u.send_frame(5'h14);
        #1;
        check("no_match", 8'(addr_match), 8'h00);
        @(posedge clock);
        low_power <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        check("pwr_down", 8'(pwr_down_10_an), 8'h01);
        @(posedge clock);
        speed_100_int <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        check("pwr_up_10", 8'(pwr_down_10_an), 8'h00);
        $display("test frames_power done");
    endtask

    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        power_on();
        soft_seq();
        frame_seq();
        wrap_up();
    end

    // Run needs about 880 cycles
    initial begin
        #20000;
        bad_count++;
        wrap_up();
    end
endmodule // testbench

`default_nettype wire
